// *** hw/prc_pkg.sv ***
package prc_pkg;

  localparam int unsigned NUM_PORTS     = 4;
  localparam int unsigned SRC_W         = 2;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned STRAP_W       = 4;
  // Strap field position inside the station address
  localparam int unsigned ADDR_STRAP_LSB = 1;
  // Values after reset
  localparam logic [4:0]  ADDR_RST      = 5'h00;
  localparam logic        REF125_RST    = 1'b0;
  // Cycles the synchronised straps settle before capture (two flops + margin)
  localparam logic [2:0]  SETTLE_CYC    = 3'h4;
  localparam logic [2:0]  CNT_RST       = 3'h0;
  // Strap level that selects the 125 MHz reference
  localparam logic        REF_SEL_125   = 1'b1;

  typedef enum logic [2:0] {
    ST_RESET  = 3'h1,
    ST_SETTLE = 3'h2,
    ST_RUN    = 3'h4
  } prc_state_e;

  // Per-output recovered clock configuration
  typedef struct packed {
    logic             en;
    logic [SRC_W-1:0] src;
  } prc_rclk_cfg_s;

  // Captured strap values
  typedef struct packed {
    logic [STRAP_W-1:0] addr;
    logic               ref125;
  } prc_strap_s;

endpackage

// *** hw/prc_sync2.sv ***
`timescale 1ns/1ps
module prc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

// *** hw/prc_top.sv ***
`timescale 1ns/1ps
module prc_top (
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [prc_pkg::STRAP_W-1:0]    station_addr_strap_i,
  input  wire logic                           ref_freq_select_i,
  input  wire logic [prc_pkg::NUM_PORTS-1:0]  media_clk_125_i,
  input  wire logic [prc_pkg::NUM_PORTS-1:0]  media_clk_25_i,
  input  wire logic [prc_pkg::NUM_PORTS-1:0]  media_gig_i,
  input  wire prc_pkg::prc_rclk_cfg_s         rclk_cfg_a_i,
  input  wire prc_pkg::prc_rclk_cfg_s         rclk_cfg_b_i,
  output logic                                powered_down_o,
  output logic                                straps_valid_o,
  output logic [prc_pkg::ADDR_W-1:0]          station_addr_o,
  output logic                                ref_125m_o,
  output logic                                recovered_clk_out_a_o,
  output logic                                recovered_clk_out_b_o
);

  import prc_pkg::*;

  // Release sequencer and captured straps
  prc_state_e state_q;
  prc_state_e state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  prc_strap_s strap_raw;
  prc_strap_s strap_sync;
  prc_strap_s strap_q;
  prc_strap_s strap_d;
  logic       run_q;
  logic       run_d;
  // Registered recovered clock selection
  logic [1:0] en_q;
  logic [1:0] en_d;
  logic [1:0] gig_q;
  logic [1:0] gig_d;
  logic [SRC_W-1:0] src_a_q;
  logic [SRC_W-1:0] src_a_d;
  logic [SRC_W-1:0] src_b_q;
  logic [SRC_W-1:0] src_b_d;
  logic [1:0] rclk_sel;

  // Straps come from board pins, so they pass two flops first
  assign strap_raw = '{addr: station_addr_strap_i, ref125: ref_freq_select_i};

  prc_sync2 #(
    .W ($bits(prc_strap_s))
  ) u_strap_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (strap_raw),
    .sync_o    (strap_sync)
  );

  // Release sequence: wait for the synchronised straps, capture, then run
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    strap_d = strap_q;
    run_d   = run_q;
    case (state_q)
      ST_RESET: begin
        state_d = ST_SETTLE;
        cnt_d   = CNT_RST;
      end
      ST_SETTLE: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == SETTLE_CYC - 3'h1) begin
          strap_d = strap_sync;
          state_d = ST_RUN;
          run_d   = 1'b1;
        end
      end
      ST_RUN: begin
        // Straps frozen until the next reset; later pin moves are ignored
        strap_d = strap_q;
      end
      default: begin
        state_d = ST_RESET;
        run_d   = 1'b0;
      end
    endcase
  end

  // Everything returns to its default on reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_RESET;
      cnt_q   <= CNT_RST;
      strap_q <= '{addr: '0, ref125: REF125_RST};
      run_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      strap_q <= strap_d;
      run_q   <= run_d;
    end
  end

  // Config is registered so the gate only changes on sys_clk edges
  always_comb begin
    en_d    = {rclk_cfg_b_i.en, rclk_cfg_a_i.en} & {2{run_q}};
    src_a_d = rclk_cfg_a_i.src;
    src_b_d = rclk_cfg_b_i.src;
    gig_d   = {media_gig_i[rclk_cfg_b_i.src], media_gig_i[rclk_cfg_a_i.src]};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q    <= 2'h0;
      src_a_q <= '0;
      src_b_q <= '0;
      gig_q   <= 2'h0;
    end else begin
      en_q    <= en_d;
      src_a_q <= src_a_d;
      src_b_q <= src_b_d;
      gig_q   <= gig_d;
    end
  end

  // Rate follows the selected source: 125 MHz at gigabit, else 25 MHz.
  // Limitation: the gate is a plain AND, so an enable change may clip one
  // recovered clock pulse; downstream PLLs tolerate that.
  always_comb begin
    rclk_sel[0] = gig_q[0] ? media_clk_125_i[src_a_q]
                           : media_clk_25_i[src_a_q];
    rclk_sel[1] = gig_q[1] ? media_clk_125_i[src_b_q]
                           : media_clk_25_i[src_b_q];
  end

  assign recovered_clk_out_a_o = rclk_sel[0] & en_q[0];
  assign recovered_clk_out_b_o = rclk_sel[1] & en_q[1];

  // Station address bits 4:1 from straps, bit 0 is zero (per-port offset)
  assign station_addr_o = {strap_q.addr, 1'b0};
  assign ref_125m_o     = strap_q.ref125;
  // Power-down follows run, so it stays high through the whole settle
  assign powered_down_o = ~run_q;
  assign straps_valid_o = run_q;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Release sequence and strap capture, plus recovered clock a rate, both-output inactive and clock b off checks
  a_pd_until_run: assert property (
    (state_q != ST_RUN) |-> powered_down_o)
    else $error("powered down released before run");

  a_defaults_held: assert property (
    (state_q == ST_SETTLE) |-> (station_addr_o == ADDR_RST)
                            && (ref_125m_o == REF125_RST))
    else $error("strap outputs left default before capture");

  a_addr_capture: assert property (
    $rose(run_q) |-> station_addr_o == {$past(strap_sync.addr), 1'b0})
    else $error("station address not taken from straps");

  a_lsb_weight: assert property (
    $rose(run_q) && $past(strap_sync.addr[0])
      |-> station_addr_o[ADDR_STRAP_LSB])
    else $error("lowest strap did not add 0x2");

  a_rclk_rate: assert property (
    en_q[0] && gig_q[0]
      |-> recovered_clk_out_a_o == media_clk_125_i[src_a_q])
    else $error("recovered clock a wrong rate");

  a_rclk_inactive: assert property (
    !run_q |=> !recovered_clk_out_a_o && !recovered_clk_out_b_o)
    else $error("recovered clock active before run");

  a_rclk_off_low: assert property (
    !en_q[1] |-> !recovered_clk_out_b_o)
    else $error("disabled recovered clock b not low");

  a_ref_select: assert property (
    $rose(run_q) |-> ref_125m_o == ($past(strap_sync.ref125) == REF_SEL_125))
    else $error("reference select not captured");

  a_straps_frozen: assert property (
    run_q && $past(run_q) |-> $stable(station_addr_o) && $stable(ref_125m_o))
    else $error("straps changed while running");

  a_settle_len: assert property (
    $rose(state_q == ST_SETTLE) |-> powered_down_o [*4] ##1 !powered_down_o)
    else $error("settle length wrong");

  a_valid_pair: assert property (
    straps_valid_o != powered_down_o)
    else $error("valid and powered down disagree");

  a_addr_bit0: assert property (
    !station_addr_o[0])
    else $error("station address bit 0 not zero");

  // Recovered clock rate and gating, then cover points
  a_rclk_slow_a: assert property (
    en_q[0] && !gig_q[0]
      |-> recovered_clk_out_a_o == media_clk_25_i[src_a_q])
    else $error("recovered clock a not at slow rate");

  a_rclk_rate_b: assert property (
    en_q[1] && gig_q[1]
      |-> recovered_clk_out_b_o == media_clk_125_i[src_b_q])
    else $error("recovered clock b wrong rate");

  a_rclk_off_a: assert property (
    !en_q[0] |-> !recovered_clk_out_a_o)
    else $error("disabled recovered clock a not low");

  a_en_needs_run: assert property (
    (en_q != 2'h0) |-> run_q)
    else $error("recovered clock enabled before run");

  c_run_reached: cover property ($rose(run_q));
  c_rclk_a_off: cover property (run_q && !en_q[0]);
  c_addr_offset: cover property ($rose(run_q) && station_addr_o[1]);
  c_rclk_a_on: cover property (en_q[0] && gig_q[0]);
  c_rclk_b_slow: cover property (en_q[1] && !gig_q[1]);

endmodule

// *** test/prc_board.sv ***
`timescale 1ns/1ps
// Board side: strap wiring plus free-running per-port media clocks
module prc_board (
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] addr_i,
  input  wire logic       ref_i,
  output logic      [3:0] strap_o,
  output logic            ref_sel_o,
  output logic      [3:0] clk125_o,
  output logic      [3:0] clk25_o
);
  logic [3:0] cnt_q = 4'h0;
  // Straps are plain wiring; lsb strap stays low unless the offset is wanted
  assign strap_o   = addr_i;
  assign ref_sel_o = ref_i;
  // Clocks move off the sampling edge, each port in its own phase
  always @(negedge sys_clk_i) cnt_q <= cnt_q + 4'h1;
  assign clk125_o  = {~cnt_q[1], cnt_q[1], ~cnt_q[0], cnt_q[0]};
  assign clk25_o   = {~cnt_q[3], cnt_q[3], ~cnt_q[2], cnt_q[2]};
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import prc_pkg::*;
  typedef struct packed {
    logic [3:0]    addr;
    logic          rsel;
    logic [3:0]    gig;
    prc_rclk_cfg_s a;
    prc_rclk_cfg_s b;
    logic [4:0]    exp_sa;
    logic          exp_ref;
  } prc_row_s;
  logic          sys_clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic [3:0]    addr = 4'h0;
  logic [3:0]    gig = 4'h0;
  logic          rsel = 1'b0;
  prc_rclk_cfg_s cfg_a = '0;
  prc_rclk_cfg_s cfg_b = '0;
  logic [3:0]    c125, c25, strap;
  logic          ref_sel, pd, sv, r125, oa, ob;
  logic [4:0]    sa;
  int            failures = 0;
  int            cmp_count = 0;
  // Straps, gig flags, both configs, then expected address and reference
  prc_row_s      rows [4] = '{'{4'h0, 1'b0, 4'h0, 3'h4, 3'h1, 5'h00, 1'b0},
                              '{4'h1, 1'b1, 4'h5, 3'h6, 3'h7, 5'h02, 1'b1},
                              '{4'hA, 1'b1, 4'hF, 3'h1, 3'h5, 5'h14, 1'b1},
                              '{4'hF, 1'b0, 4'hA, 3'h7, 3'h6, 5'h1E, 1'b0}};

  // 200 MHz system clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  prc_board prc_board_i (.sys_clk_i(sys_clk_i), .addr_i(addr), .ref_i(rsel),
    .strap_o(strap), .ref_sel_o(ref_sel), .clk125_o(c125), .clk25_o(c25));
  prc_top prc_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .station_addr_strap_i(strap), .ref_freq_select_i(ref_sel),
    .media_clk_125_i(c125), .media_clk_25_i(c25), .media_gig_i(gig),
    .rclk_cfg_a_i(cfg_a), .rclk_cfg_b_i(cfg_b), .powered_down_o(pd),
    .straps_valid_o(sv), .station_addr_o(sa), .ref_125m_o(r125),
    .recovered_clk_out_a_o(oa), .recovered_clk_out_b_o(ob));

  task automatic check(string name, logic [4:0] seen, logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset held long enough for the board to settle; run starts on edge 5
  task automatic boot();
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1 check("pd_early", pd, 1'b1);
    check("out_a_early", oa, 1'b0);
    @(posedge sys_clk_i);
    #1 check("pd", pd, 1'b0);
    check("valid", sv, 1'b1);
  endtask

  function automatic logic exp_clk(prc_rclk_cfg_s c);
    return c.en & (gig[c.src] ? c125[c.src] : c25[c.src]);
  endfunction

  // Outputs sampled 1 ns after each posedge, clear of the negedge media clock changes
  task automatic clk_chk();
    repeat (8) begin
      @(posedge sys_clk_i);
      #1 check("out_a", oa, exp_clk(cfg_a));
      check("out_b", ob, exp_clk(cfg_b));
    end
  endtask

  // Table rows first, then capture hold and reset in mid-run
  initial begin
    foreach (rows[i]) begin
      @(negedge sys_clk_i);
      addr  = rows[i].addr;
      rsel  = rows[i].rsel;
      gig   = rows[i].gig;
      cfg_a = rows[i].a;
      cfg_b = rows[i].b;
      boot();
      check("addr", sa, rows[i].exp_sa);
      check("ref", r125, rows[i].exp_ref);
      @(posedge sys_clk_i);
      clk_chk();
      $display("row %0d done", i);
    end
    @(negedge sys_clk_i);
    addr = 4'h0;
    rsel = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    check("addr_held", sa, 5'h1E);
    check("ref_held", r125, 1'b0);
    $display("strap hold done");
    rst_n_i = 1'b0;
    repeat (3) begin
      @(posedge sys_clk_i);
      #1 check("rst_pd", pd, 1'b1);
      check("rst_addr", sa, 5'h00);
      check("rst_ref", r125, 1'b0);
      check("rst_valid", sv, 1'b0);
      check("rst_clk", {oa, ob}, 2'h0);
    end
    $display("mid-run reset done");
    report_and_stop();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #5000;
    failures++;
    report_and_stop();
  end
endmodule
